//--- src/tilt_regs.svh
`ifndef TILT_REGS_SVH
`define TILT_REGS_SVH

// Parameter indexes
`define IDX_CYC_TX 16'h1000
`define IDX_NODE 16'h2000
`define IDX_RATE 16'h2001
`define IDX_QUAD 16'h2040
`define IDX_HEAT 16'h2041
`define IDX_TEACH 16'h2042
`define IDX_FILT 16'h2043
`define IDX_MODE 16'h2044
`define IDX_TERM 16'h2045
`define IDX_ZERO 16'h2046
`define IDX_CTEMP 16'h2081
`define IDX_KEY 16'h3000
`define IDX_STEST 16'h4008
`define IDX_SRES 16'h4009

// Factory values
`define RST_CYC_TX 8'h01
`define RST_NODE 8'h19
`define RST_RATE 16'h00fa
`define RST_QUAD 8'h01
`define RST_HEAT 8'h01
`define RST_TEACH 8'h02
`define RST_FILT 8'h02
`define RST_MODE 8'h00
`define RST_TERM 8'h01
`define RST_ZERO 8'h02

// Codes shared by teach and zero point
`define SEL_KEEP 8'h00
`define SEL_SET 8'h01
`define SEL_CLR 8'h02

// Angle modes and quadrant extension
`define MODE_PERP 8'h00
`define MODE_EULER 8'h01
`define MODE_GIMX 8'h02
`define MODE_GIMY 8'h03
`define QUAD_PM180 8'h01
`define QUAD_360 8'h02

// Timing
`define CLK_KHZ 100000
`define TEMP_MS 200
`define STEST_MS 2000

// Heater regulation setpoint, tenths of a degree
`define HEAT_SETPT 16'sh01f4

// Key checksum
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff

`endif

//--- src/tilt_pkg.sv
package tilt_pkg;

    typedef struct packed {
        logic [15:0] idx;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } prm_req_t;

    typedef struct packed {
        logic signed [15:0] lon;
        logic signed [15:0] lat;
    } angle_pair_t;

    typedef struct packed {
        logic [7:0] node;
        logic [15:0] rate;
        logic [7:0] quad;
        logic [7:0] heat;
        logic [7:0] teach;
        logic [7:0] filt;
        logic [7:0] mode;
        logic [7:0] term;
        logic [7:0] zero;
        logic [31:0] pad;
        logic [15:0] crc;
    } setup_key_t;

    typedef enum logic {ST_IDLE, ST_RUN} stest_state_t;

endpackage

//--- src/param_key_crc.sv
`timescale 1ns/1ns
`include "tilt_regs.svh"

module param_key_crc
(
    // Key body without checksum
    input wire logic [111:0] payload,
    // Checksum of the body
    output logic [15:0] crc
);

    function automatic logic [15:0] crc16(input logic [111:0] d);
        logic [15:0] c;
        c = `CRC_INIT;
        for (int i = 111; i >= 0; i--)
        begin
            if (c[15] ^ d[i])
                c = {c[14:0], 1'b0} ^ `CRC_POLY;
            else
                c = {c[14:0], 1'b0};
        end
        return c;
    endfunction

    assign crc = crc16(payload);

endmodule // param_key_crc

//--- src/tilt_sensor_parameter_bank.sv
`timescale 1ns/1ns
`include "tilt_regs.svh"
module tilt_sensor_parameter_bank
#(
    parameter int unsigned TEMP_CYC = `TEMP_MS * `CLK_KHZ,
    parameter int unsigned STEST_CYC = `STEST_MS * `CLK_KHZ
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Parameter access by index
    input wire tilt_pkg::prm_req_t prmReq,
    output logic prmAck,
    output logic prmErr,
    output logic [15:0] prmRdata,
    // Setup key
    input wire logic keyWr,
    input wire tilt_pkg::setup_key_t keyWdata,
    output tilt_pkg::setup_key_t keyRdata,
    output logic keyAck,
    output logic keyBad,
    // Application or communication reset command
    input wire logic resetCmd,
    // Sensing cell
    input wire logic rawValid,
    input wire tilt_pkg::angle_pair_t rawAngle,
    input wire logic [15:0] cellTempIn,
    input wire logic [2:0] axisOk,
    output logic selfTestRun,
    // Angle output
    output tilt_pkg::angle_pair_t angleOut,
    output logic angleValid,
    output tilt_pkg::angle_pair_t zeroOffset,
    output logic zeroStore,
    // Bus and device control
    output logic [7:0] nodeAddr,
    output logic [15:0] bitRate,
    output logic cyclicTxEn,
    output logic termEnable,
    output logic heaterOn,
    output logic [7:0] heaterDuty,
    input wire logic runState,
    output logic ledGreen
);
    import tilt_pkg::*;

    function automatic logic signed [15:0] firAvg(input logic signed [15:0] h [16],
                                                  input logic [7:0] step);
        logic signed [19:0] acc;
        int n;
        acc = '0;
        n = 1 << step[2:0];
        for (int i = 0; i < 16; i++)
        begin
            if (i < n)
                acc = acc + 20'(h[i]);
        end
        return 16'(acc >>> step[2:0]);
    endfunction

    function automatic logic signed [15:0] satSub(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        if (d > 17'sh07fff)
            return 16'sh7fff;
        if (d < -17'sh08000)
            return 16'sh8000;
        return 16'(d);
    endfunction

    function automatic logic [15:0] abs16(input logic signed [15:0] a);
        return a[15] ? 16'(-a) : 16'(a);
    endfunction

    stest_state_t stState;
    logic [31:0] stCnt;
    logic [31:0] tempCnt;
    logic [7:0] cycTx, nodePend, quad, heat, teach, filt, mode, term, zero;
    logic [15:0] ratePend;
    logic signed [15:0] cellTemp;
    logic [7:0] stestRes;
    angle_pair_t teachRef;
    logic signed [15:0] histX [16];
    logic signed [15:0] histY [16];
    logic filtValid;
    logic signed [23:0] pidInt;
    logic signed [17:0] pidPrev;

    // Write decode
    wire [15:0] idx = prmReq.idx;
    wire [7:0] wd8 = prmReq.wdata[7:0];
    wire wrLegal = prmReq.wr && prmReq.wdata[15:8] == 8'h00 && (
        (idx == `IDX_CYC_TX && wd8 <= 8'h01) || idx == `IDX_NODE ||
        (idx == `IDX_QUAD && wd8 <= 8'h02) || (idx == `IDX_HEAT && wd8 <= 8'h01) ||
        (idx == `IDX_TEACH && wd8 <= 8'h02) || (idx == `IDX_FILT && wd8 <= 8'h04) ||
        (idx == `IDX_MODE && wd8 <= 8'h03) || (idx == `IDX_TERM && wd8 <= 8'h01) ||
        (idx == `IDX_ZERO && wd8 <= 8'h02) || (idx == `IDX_STEST && wd8 <= 8'h01));
    wire wrTeach = wrLegal && idx == `IDX_TEACH;
    wire wrZero = wrLegal && idx == `IDX_ZERO;
    wire wrHeat = wrLegal && idx == `IDX_HEAT;
    wire stestStart = wrLegal && idx == `IDX_STEST && wd8 == 8'h01;
    wire rdKnown = idx inside {`IDX_CYC_TX, `IDX_NODE, `IDX_RATE, `IDX_QUAD, `IDX_HEAT,
        `IDX_TEACH, `IDX_FILT, `IDX_MODE, `IDX_TERM, `IDX_ZERO, `IDX_CTEMP,
        `IDX_STEST, `IDX_SRES};
    wire [15:0] rdMux =
        idx == `IDX_CYC_TX ? {8'h00, cycTx} :
        idx == `IDX_NODE ? {8'h00, nodePend} :
        idx == `IDX_RATE ? ratePend :
        idx == `IDX_QUAD ? {8'h00, quad} :
        idx == `IDX_HEAT ? {8'h00, heat} :
        idx == `IDX_TEACH ? {8'h00, teach} :
        idx == `IDX_FILT ? {8'h00, filt} :
        idx == `IDX_MODE ? {8'h00, mode} :
        idx == `IDX_TERM ? {8'h00, term} :
        idx == `IDX_ZERO ? {8'h00, zero} :
        idx == `IDX_CTEMP ? 16'(cellTemp) :
        idx == `IDX_STEST ? {15'h0000, selfTestRun} :
        idx == `IDX_SRES ? {8'h00, stestRes} : 16'h0000;

    // Setup key: body is checksummed both ways
    wire [111:0] keyPay = {nodePend, ratePend, quad, heat, teach, filt, mode, term, zero,
                           32'h00000000};
    wire [15:0] keyPayCrc;
    wire [15:0] keyInCrc;
    param_key_crc keyOutCrc
    (
        .payload(keyPay),
        .crc(keyPayCrc)
    );
    param_key_crc keyInCheck
    (
        .payload(keyWdata[127:16]),
        .crc(keyInCrc)
    );
    wire keyFieldsOk = keyWdata.quad <= 8'h02 && keyWdata.heat <= 8'h01 &&
        keyWdata.teach <= 8'h02 && keyWdata.filt <= 8'h04 && keyWdata.mode <= 8'h03 &&
        keyWdata.term <= 8'h01 && keyWdata.zero <= 8'h02;
    wire keyGood = keyWr && keyInCrc == keyWdata.crc && keyFieldsOk;

    // Filter, then zero point, then teach
    wire signed [15:0] fx = firAvg(histX, filt);
    wire signed [15:0] fy = firAvg(histY, filt);
    wire signed [15:0] zx = zero == `SEL_SET ? satSub(fx, zeroOffset.lon) : fx;
    wire signed [15:0] zy = zero == `SEL_SET ? satSub(fy, zeroOffset.lat) : fy;
    wire signed [15:0] tx = teach == `SEL_SET ? satSub(zx, teachRef.lon) : zx;
    wire signed [15:0] ty = teach == `SEL_SET ? satSub(zy, teachRef.lat) : zy;

    // Euler: slope is the larger tilt, direction coarse in 45 degree sectors
    wire signed [15:0] eastV = satSub(16'sh0000, ty);
    wire [15:0] absE = abs16(eastV);
    wire [15:0] absN = abs16(tx);
    wire nearE = {absN, 1'b0} < {1'b0, absE};
    wire nearN = {absE, 1'b0} < {1'b0, absN};
    wire [2:0] sect = !eastV[15] ?
        (!tx[15] ? (nearE ? 3'h0 : nearN ? 3'h2 : 3'h1) :
                   (nearE ? 3'h0 : nearN ? 3'h6 : 3'h7)) :
        (!tx[15] ? (nearE ? 3'h4 : nearN ? 3'h2 : 3'h3) :
                   (nearE ? 3'h4 : nearN ? 3'h6 : 3'h5));
    wire [15:0] dir360 = 16'(sect) * 16'h01c2;
    wire [15:0] dirOut = (quad == `QUAD_360 || dir360 <= 16'h0708) ? dir360 :
                         dir360 - 16'h0e10;
    wire [15:0] eulerLon = absN > absE ? absN : absE;
    wire isEuler = mode == `MODE_EULER;
    // Perpendicular and both gimbal orders share one path, so single-axis tilt agrees
    wire angle_pair_t nextAngle = isEuler ? {eulerLon, dirOut} : {tx, ty};

    // Heater regulation
    wire signed [17:0] pidErr = 18'(`HEAT_SETPT) - 18'(cellTemp);
    wire signed [23:0] pidSum = (24'(pidErr) <<< 2) + (pidInt >>> 4) +
                                (24'(pidErr - pidPrev) <<< 1);
    wire [7:0] dutyNext = pidSum < 0 ? 8'h00 : pidSum > 24'sh0000ff ? 8'hff : pidSum[7:0];
    // Integrate only while not pushing into a rail, to avoid windup
    wire pidHold = (dutyNext == 8'hff && pidErr > 0) || (dutyNext == 8'h00 && pidErr < 0);
    wire tempTick = tempCnt == TEMP_CYC - 1;
    wire stestDone = stState == ST_RUN && stCnt == STEST_CYC - 1;

    // Parameter storage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cycTx <= `RST_CYC_TX;
            nodePend <= `RST_NODE;
            ratePend <= `RST_RATE;
            quad <= `RST_QUAD;
            heat <= `RST_HEAT;
            teach <= `RST_TEACH;
            filt <= `RST_FILT;
            mode <= `RST_MODE;
            term <= `RST_TERM;
            zero <= `RST_ZERO;
        end
        else if (wrLegal)
        begin
            if (idx == `IDX_CYC_TX)
                cycTx <= wd8;
            if (idx == `IDX_NODE)
                nodePend <= wd8;
            if (idx == `IDX_QUAD)
                quad <= wd8;
            if (wrHeat)
                heat <= wd8;
            if (wrTeach && wd8 != `SEL_KEEP)
                teach <= wd8;
            if (idx == `IDX_FILT)
                filt <= wd8;
            if (idx == `IDX_MODE)
                mode <= wd8;
            if (idx == `IDX_TERM)
                term <= wd8;
            if (wrZero && wd8 != `SEL_KEEP)
                zero <= wd8;
        end
        else if (keyGood)
        begin
            nodePend <= keyWdata.node;
            ratePend <= keyWdata.rate;
            quad <= keyWdata.quad;
            heat <= keyWdata.heat;
            filt <= keyWdata.filt;
            mode <= keyWdata.mode;
            term <= keyWdata.term;
            if (keyWdata.teach != `SEL_KEEP)
                teach <= keyWdata.teach;
            if (keyWdata.zero != `SEL_KEEP)
                zero <= keyWdata.zero;
        end
    end

    // Bus identity switches only on a reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            nodeAddr <= `RST_NODE;
            bitRate <= `RST_RATE;
        end
        else if (resetCmd)
        begin
            nodeAddr <= nodePend;
            bitRate <= ratePend;
        end
    end

    // Access answers, one cycle after the request
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            prmAck <= 1'b0;
            prmErr <= 1'b0;
            prmRdata <= 16'h0000;
            keyAck <= 1'b0;
            keyBad <= 1'b0;
            keyRdata <= '0;
        end
        else
        begin
            prmAck <= prmReq.wr || prmReq.rd;
            prmErr <= (prmReq.wr && !wrLegal) || (prmReq.rd && !rdKnown);
            if (prmReq.rd)
                prmRdata <= rdMux;
            keyAck <= keyWr;
            keyBad <= keyWr && !keyGood;
            keyRdata <= {keyPay, keyPayCrc};
        end
    end

    // Reference captures; zero offset goes to nonvolatile storage via zeroStore
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            zeroOffset <= '0;
            teachRef <= '0;
            zeroStore <= 1'b0;
        end
        else
        begin
            zeroStore <= wrZero && wd8 == `SEL_SET;
            if (wrZero && wd8 == `SEL_SET)
                zeroOffset <= {fx, fy};
            if (wrTeach && wd8 == `SEL_SET)
                teachRef <= {zx, zy};
        end
    end

    // Filter history and output pair
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < 16; i++)
            begin
                histX[i] <= 16'sh0000;
                histY[i] <= 16'sh0000;
            end
            filtValid <= 1'b0;
            angleValid <= 1'b0;
            angleOut <= '0;
        end
        else
        begin
            if (rawValid)
            begin
                histX[0] <= rawAngle.lon;
                histY[0] <= rawAngle.lat;
                for (int i = 1; i < 16; i++)
                begin
                    histX[i] <= histX[i-1];
                    histY[i] <= histY[i-1];
                end
            end
            filtValid <= rawValid;
            angleValid <= filtValid;
            if (filtValid)
                angleOut <= nextAngle;
        end
    end

    // Cell temperature sampling and heater
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            tempCnt <= 32'h00000000;
            cellTemp <= 16'sh0000;
        end
        else
        begin
            tempCnt <= tempTick ? 32'h00000000 : tempCnt + 32'h00000001;
            if (tempTick)
                cellTemp <= cellTempIn;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst || heat == 8'h00)
        begin
            pidInt <= 24'sh000000;
            pidPrev <= 18'sh00000;
            heaterDuty <= 8'h00;
            heaterOn <= 1'b0;
        end
        else
        begin
            heaterOn <= 1'b1;
            if (tempTick)
            begin
                if (!pidHold)
                    pidInt <= pidInt + 24'(pidErr);
                pidPrev <= pidErr;
                heaterDuty <= dutyNext;
            end
        end
    end

    // Self-test; a start landing on the final cycle restarts rather than being lost
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stState <= ST_IDLE;
            stCnt <= 32'h00000000;
            selfTestRun <= 1'b0;
            stestRes <= 8'h00;
        end
        else
        begin
            unique case (stState)
                ST_IDLE:
                    if (stestStart)
                    begin
                        stState <= ST_RUN;
                        selfTestRun <= 1'b1;
                        stCnt <= 32'h00000000;
                    end
                ST_RUN:
                    if (stestDone)
                    begin
                        stestRes <= {5'h00, axisOk};
                        stCnt <= 32'h00000000;
                        if (!stestStart)
                        begin
                            stState <= ST_IDLE;
                            selfTestRun <= 1'b0;
                        end
                    end
                    else
                        stCnt <= stCnt + 32'h00000001;
            endcase
        end
    end

    // Pin-level controls
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cyclicTxEn <= 1'b0;
            termEnable <= 1'b0;
            ledGreen <= 1'b0;
        end
        else
        begin
            cyclicTxEn <= cycTx == 8'h01;
            termEnable <= term == 8'h01;
            ledGreen <= runState;
        end
    end

    node_hold_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $changed(nodeAddr) |-> $past(resetCmd || srst))
        else $error("Node address changed without a reset");

    factory_ident_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $fell(srst) |-> (nodeAddr == `RST_NODE && bitRate == `RST_RATE) ##1 cyclicTxEn)
        else $error("Factory address, rate or cyclic send wrong");

    filter_bypass_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        rawValid && filt == 8'h00 && !prmReq.wr && !keyWr |=> fx == $past(rawAngle.lon))
        else $error("Bypassed filter does not pass the sample");

    zero_capture_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        wrZero && wd8 == `SEL_SET |=> zeroStore && zeroOffset == $past({fx, fy}))
        else $error("Zero offset not captured");

    term_switch_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        wrLegal && idx == `IDX_TERM && wd8 == 8'h01 |=> ##1 termEnable)
        else $error("Termination not switched on");

    euler_range_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        angleValid && $past(isEuler) && $past(quad) == `QUAD_360 |-> !angleOut.lat[15])
        else $error("Euler lateral negative in 0-360 range");

    heat_stop_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        wrHeat && wd8 == 8'h00 |=> ##1 heaterDuty == 8'h00 && !heaterOn)
        else $error("Heater still driven after heating off");

    temp_period_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $changed(cellTemp) |-> $past(tempCnt) == TEMP_CYC - 1)
        else $error("Cell temperature updated off the sample period");

    stest_len_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $fell(selfTestRun) |-> $past(stCnt) == STEST_CYC - 1)
        else $error("Self-test flag cleared at wrong time");

    stest_result_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        $fell(selfTestRun) |-> stestRes == {5'h00, $past(axisOk)})
        else $error("Self-test result not captured");

    key_reject_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        keyWr && !prmReq.wr && keyInCrc != keyWdata.crc |=> keyBad && $stable(quad))
        else $error("Bad key accepted");

    pair_out_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        rawValid |-> ##2 angleValid)
        else $error("Angle pair not published two cycles after sample");

    led_run_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        runState ##1 runState |-> ledGreen)
        else $error("LED not on in run state");

endmodule // tilt_sensor_parameter_bank

//--- verification/bus_host.sv
`timescale 1ns/1ns
module bus_host
(
    // Clock
    input wire logic clk_sys,
    // Parameter port
    output tilt_pkg::prm_req_t prmReq,
    input wire logic prmAck,
    input wire logic prmErr,
    input wire logic [15:0] prmRdata
);
    import tilt_pkg::*;
    int errs = 0;
    int cmps = 0;
    logic [17:0] notes[$];
    logic [17:0] note;
    initial prmReq = '0;
    // Note is {check data, error, data}; idle fields inverted so stale values never match
    task automatic access(input logic [15:0] idx, input logic wr, input logic [15:0] wd,
                          input logic [17:0] exp);
        @(posedge clk_sys);
        #1;
        notes.push_back(exp);
        prmReq = '{idx: idx, wr: wr, rd: ~wr, wdata: wd};
        @(posedge clk_sys);
        #1;
        prmReq = '{idx: ~idx, wr: 1'b0, rd: 1'b0, wdata: ~wd};
    endtask
    always @(posedge clk_sys)
    begin
        if (prmAck === 1'b1)
        begin
            note = notes.size() ? notes.pop_front() : 18'h3ffff;
            cmps++;
            if (prmErr !== note[16] || (note[17] && prmRdata !== note[15:0]))
            begin
                errs++;
                $display("[ERR] prm answer expected %h seen %h", note[16:0], {prmErr, prmRdata});
            end
        end
    end
endmodule // bus_host

//--- verification/tilt_sensor_parameter_bank_tb_top.sv
`timescale 1ns/1ns
module tilt_sensor_parameter_bank_tb_top;
    import tilt_pkg::*;
    logic clk_sys, srst, prmAck, prmErr, keyWr, keyAck, keyBad, resetCmd, rawValid;
    logic selfTestRun, angleValid, zeroStore, cyclicTxEn, termEnable, heaterOn;
    logic runState, ledGreen;
    logic [15:0] prmRdata, cellTempIn, bitRate;
    logic [7:0] nodeAddr, heaterDuty, val;
    logic [2:0] axisOk;
    prm_req_t prmReq;
    setup_key_t keyWdata, keyRdata;
    angle_pair_t rawAngle, angleOut, zeroOffset, pr;
    int n_errors = 0;
    int compares = 0;
    int seed = 88;
    logic [15:0] idxTab[10] = '{16'h1000, 16'h2000, 16'h2001, 16'h2040, 16'h2041,
                                16'h2042, 16'h2043, 16'h2044, 16'h2045, 16'h2046};
    logic [15:0] rstTab[10] = '{16'h1, 16'h19, 16'hfa, 16'h1, 16'h1, 16'h2, 16'h2, 16'h0,
                                16'h1, 16'h2};
    tilt_sensor_parameter_bank #(.TEMP_CYC(16), .STEST_CYC(20)) dut_u
    (.clk_sys, .srst, .prmReq, .prmAck, .prmErr, .prmRdata, .keyWr, .keyWdata, .keyRdata,
     .keyAck, .keyBad, .resetCmd, .rawValid, .rawAngle, .cellTempIn, .axisOk, .selfTestRun,
     .angleOut, .angleValid, .zeroOffset, .zeroStore, .nodeAddr, .bitRate, .cyclicTxEn,
     .termEnable, .heaterOn, .heaterDuty, .runState, .ledGreen);
    bus_host host_u (.clk_sys, .prmReq, .prmAck, .prmErr, .prmRdata);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] wd, input logic err);
        host_u.access(idx, 1'b1, wd, {1'b0, err, 16'h0});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        host_u.access(idx, 1'b0, 16'h0, {2'b10, exp});
    endtask
    // Feeds one sample, looks at the output one edge after it is taken
    task automatic sample(input angle_pair_t exp);
        @(posedge clk_sys);
        #1 rawValid = 1;
        @(posedge clk_sys);
        #1 rawValid = 0;
        rawAngle = ~rawAngle;
        @(posedge clk_sys);
        #1 chk("angle", {1'b1, exp[31:1]}, {angleValid, angleOut[31:1]});
    endtask
    task automatic key(input logic bad);
        @(posedge clk_sys);
        #1 keyWdata = keyRdata ^ {127'h0, bad};
        keyWr = 1;
        @(posedge clk_sys);
        #1 keyWr = 0;
        chk("key", {1'b1, bad}, {keyAck, keyBad});
    endtask
    task automatic print_verdict;
        n_errors += host_u.errs;
        compares += host_u.cmps;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #100000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        {srst, keyWr, resetCmd, rawValid, runState} = 5'b10000;
        keyWdata = '0;
        rawAngle = '0;
        cellTempIn = 16'($random(seed));
        axisOk = 3'($random(seed));
        val = 8'($random(seed));
        repeat (4) @(posedge clk_sys);
        #1 srst = 0;
        @(posedge clk_sys);
        #1 chk("boot", {8'h19, 16'h00fa, 3'b111}, {nodeAddr, bitRate, cyclicTxEn, termEnable, heaterOn});
        foreach (idxTab[i]) rd(idxTab[i], rstTab[i]);
        wr(16'h2000, {8'h0, val}, 0);
        chk("node kept", 8'h19, nodeAddr);
        resetCmd = 1;
        @(posedge clk_sys);
        #1 resetCmd = 0;
        @(posedge clk_sys);
        #1 chk("node new", val, nodeAddr);
        wr(16'h2001, 16'h1, 1);
        wr(16'h2043, 16'h5, 1);
        for (int f = 4; f >= 0; f--) wr(16'h2043, 16'(f), 0);
        rd(16'h2043, 16'h0);
        wr(16'h2045, 16'h0, 0);
        wr(16'h2041, 16'h0, 0);
        @(posedge clk_sys);
        #1 chk("term heat", 10'h000, {termEnable, heaterOn, heaterDuty});
        wr(16'h2045, 16'h1, 0);
        wr(16'h2042, 16'h0, 0);
        wr(16'h2046, 16'h0, 0);
        rd(16'h2042, 16'h2);
        rd(16'h2046, 16'h2);
        rd(16'h2081, cellTempIn);
        rd(16'h2045, 16'h1);
        pr = angle_pair_t'($random(seed));
        rawAngle = pr;
        sample(pr);
        wr(16'h2046, 16'h1, 0);
        chk("store", 1'b1, zeroStore);
        repeat (2) @(posedge clk_sys);
        #1 chk("offset", pr, zeroOffset);
        rawAngle = pr;
        sample('0);
        wr(16'h2046, 16'h2, 0);
        rawAngle = pr;
        sample(pr);
        wr(16'h2043, 16'h1, 0);
        rawAngle = '0;
        sample({pr.lon >>> 1, pr.lat >>> 1});
        wr(16'h2043, 16'h0, 0);
        rawAngle = pr;
        sample(pr);
        wr(16'h2042, 16'h1, 0);
        rawAngle = pr;
        sample('0);
        wr(16'h2042, 16'h2, 0);
        wr(16'h2044, 16'h3, 0);
        rawAngle = pr;
        sample(pr);
        wr(16'h2044, 16'h1, 0);
        wr(16'h2040, 16'h2, 0);
        rawAngle = {16'hfed4, 16'h012c};
        sample({16'h012c, 16'h08ca});
        wr(16'h2040, 16'h1, 0);
        rawAngle = {16'hfed4, 16'h012c};
        sample({16'h012c, 16'hfaba});
        wr(16'h4008, 16'h1, 0);
        chk("test run", 1'b1, selfTestRun);
        for (int n = 0; n < 40 && selfTestRun !== 1'b0; n++) @(posedge clk_sys);
        #1 chk("test end", 1'b0, selfTestRun);
        rd(16'h4008, 16'h0);
        rd(16'h4009, {13'h0, axisOk});
        key(1);
        key(0);
        chk("key node", val, keyRdata.node);
        runState = 1;
        repeat (2) @(posedge clk_sys);
        #1 chk("led", 1'b1, ledGreen);
        print_verdict();
    end
endmodule // tilt_sensor_parameter_bank_tb_top
